// ---- hw/cbst_regs.vh ----
`ifndef CBST_REGS_VH
`define CBST_REGS_VH
// register port offsets (word index)
`define CBST_REG_PERI_LO 4'h0
`define CBST_REG_PERI_HI 4'h1
`define CBST_REG_SLOW_LO 4'h2
`define CBST_REG_SLOW_HI 4'h3
`define CBST_REG_MODE 4'h4
`define CBST_REG_STATUS 4'h5
`define CBST_REG_PC 4'h6
`define CBST_REG_CCR 4'h7
`define CBST_REG_SP 4'h8
// reset values
`define CBST_RST_PERI_LO 16'hff80
`define CBST_RST_PERI_HI 16'hffff
`define CBST_RST_SLOW_LO 16'h0001
`define CBST_RST_SLOW_HI 16'h0000
`define CBST_RST_SP 16'hff80
`define CBST_RST_CCR 8'h80
`define CBST_RESET_VEC 16'h0000
// mode register fields
`define CBST_MODE_RUN_LSB 0
`define CBST_MODE_HALT_LSB 4
// condition code bit positions
`define CBST_CC_C 0
`define CBST_CC_V 1
`define CBST_CC_Z 2
`define CBST_CC_N 3
`define CBST_CC_I 7
// operation codes
`define CBST_OP_NOP 4'h0
`define CBST_OP_BCC 4'h1
`define CBST_OP_JMP 4'h2
`define CBST_OP_BSR 4'h3
`define CBST_OP_JSR 4'h4
`define CBST_OP_RTS 4'h5
`define CBST_OP_RTE 4'h6
`define CBST_OP_SLEEP 4'h7
`define CBST_OP_LDCI 4'h8
`define CBST_OP_LDCR 4'h9
`define CBST_OP_STC 4'ha
`define CBST_OP_AND_COND_CODES 4'hb
`define CBST_OP_ORC 4'hc
`define CBST_OP_XOR_COND_CODES 4'hd
`define CBST_OP_MOVE 4'he
// top level cpu states
`define CBST_CPU_RESET 2'h0
`define CBST_CPU_EXEC 2'h1
`define CBST_CPU_HALT 2'h2
`define CBST_CPU_EXC 2'h3
// halt modes
`define CBST_HALT_SLEEP_HI 3'h0
`define CBST_HALT_SLEEP_MED 3'h1
`define CBST_HALT_STANDBY 3'h2
`define CBST_HALT_WATCH 3'h3
`define CBST_HALT_SUBSLEEP 3'h4
// run modes
`define CBST_RUN_SUB 2'h2
// bus timing, last state index of a cycle
`define CBST_LAST_2ST 2'h1
`define CBST_LAST_3ST 2'h2
`endif

// ---- hw/cbst_core.v ----
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`include "cbst_regs.vh"
module cbst_core (
	input wire clk_sys,
	input wire rst,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	input wire instr_valid,
	input wire [3:0] instr_op,
	input wire [3:0] instr_cond,
	input wire [7:0] instr_disp,
	input wire [15:0] instr_addr,
	input wire [7:0] instr_imm,
	input wire [7:0] instr_rdata,
	input wire [2:0] instr_ridx,
	input wire [7:0] instr_count,
	input wire [15:0] instr_src,
	input wire [15:0] instr_dst,
	output reg instr_ready_q,
	output reg gr_wr_q,
	output reg [2:0] gr_idx_q,
	output reg [7:0] gr_wdata_q,
	output reg mv_wb_q,
	output reg [7:0] mv_count_q,
	output reg [15:0] mv_src_q,
	output reg [15:0] mv_dst_q,
	input wire irq_req,
	input wire [15:0] irq_vec,
	input wire wake,
	output reg bus_req_q,
	output reg bus_we_q,
	output reg bus_word_q,
	output reg bus_three_q,
	output reg [1:0] bus_state_q,
	output reg [15:0] bus_addr_q,
	output reg [15:0] bus_wdata_q,
	input wire [15:0] bus_rdata,
	output reg [15:0] pc_q,
	output reg [7:0] ccr_q,
	output reg [15:0] sp_q,
	output reg [1:0] cpu_state_q,
	output reg [2:0] halt_mode_q,
	output reg [1:0] run_mode_q,
	output reg clk_sub_sel_q
);
	localparam ST_RST = 4'h0;
	localparam ST_VEC = 4'h1;
	localparam ST_EXEC = 4'h2;
	localparam ST_CALL = 4'h3;
	localparam ST_XPC = 4'h4;
	localparam ST_XCCR = 4'h5;
	localparam ST_XVEC = 4'h6;
	localparam ST_POPC = 4'h7;
	localparam ST_POPP = 4'h8;
	localparam ST_MVR = 4'h9;
	localparam ST_MVW = 4'ha;
	localparam ST_HALT = 4'hb;

	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [15:0] ret_q;
	reg [15:0] tgt_q;
	reg [15:0] vec_q;
	reg [7:0] mv_byte_q;
	reg [15:0] peri_lo_q;
	reg [15:0] peri_hi_q;
	reg [15:0] slow_lo_q;
	reg [15:0] slow_hi_q;
	reg [1:0] cfg_run_q;
	reg [2:0] cfg_halt_q;
	reg [1:0] bus_last_q;
	reg [15:0] acc_addr;
	reg [15:0] acc_wdata;
	reg acc_we;
	reg acc_word;
	wire accept;
	wire irq_take;
	wire bus_done;
	wire bus_idle_st;
	wire [15:0] pc_inc;
	wire [15:0] pc_rel;

	// branch condition evaluation on the current flags
	function cond_true;
		input [3:0] cc;
		input [7:0] f;
		reg nv;
		begin
			nv = f[`CBST_CC_N] ^ f[`CBST_CC_V];
			case (cc)
				4'h0: cond_true = 1'b1; // branch_always
				4'h1: cond_true = 1'b0; // branch_never
				4'h2: cond_true = ~(f[`CBST_CC_C] | f[`CBST_CC_Z]);
				4'h3: cond_true = f[`CBST_CC_C] | f[`CBST_CC_Z];
				4'h4: cond_true = ~f[`CBST_CC_C];
				4'h5: cond_true = f[`CBST_CC_C];
				4'h6: cond_true = ~f[`CBST_CC_Z];
				4'h7: cond_true = f[`CBST_CC_Z];
				4'h8: cond_true = ~f[`CBST_CC_V];
				4'h9: cond_true = f[`CBST_CC_V];
				4'ha: cond_true = ~f[`CBST_CC_N];
				4'hb: cond_true = f[`CBST_CC_N];
				4'hc: cond_true = ~nv;
				4'hd: cond_true = nv;
				4'he: cond_true = ~(f[`CBST_CC_Z] | nv);
				default: cond_true = f[`CBST_CC_Z] | nv;
			endcase
		end
	endfunction

	// inclusive address window test, shared by both decodes
	function in_win;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_win = (a >= lo) && (a <= hi);
		end
	endfunction

	// top level class of each sequencer state
	function [1:0] cpu_class;
		input [3:0] s;
		begin
			case (s)
				ST_RST: cpu_class = `CBST_CPU_RESET;
				ST_VEC, ST_XPC, ST_XCCR, ST_XVEC: cpu_class = `CBST_CPU_EXC;
				ST_HALT: cpu_class = `CBST_CPU_HALT;
				default: cpu_class = `CBST_CPU_EXEC;
			endcase
		end
	endfunction

	assign pc_inc = pc_q + 16'h0002;
	assign pc_rel = pc_inc + {{8{instr_disp[7]}}, instr_disp};
	assign accept = instr_valid && instr_ready_q;
	// interrupts only slip in between instructions, never beside one
	assign irq_take = instr_ready_q && !instr_valid && irq_req && !ccr_q[`CBST_CC_I];
	assign bus_done = bus_req_q && (bus_state_q == bus_last_q);
	assign bus_idle_st = (state_q == ST_RST) || (state_q == ST_EXEC) || (state_q == ST_HALT);

	// next sequencer state, one state code at a time
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RST: state_d = ST_VEC;
			ST_VEC, ST_XVEC, ST_POPP: begin
				if (bus_done) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (irq_take) begin
					state_d = ST_XPC;
				end else if (accept) begin
					case (instr_op)
						`CBST_OP_BSR, `CBST_OP_JSR: state_d = ST_CALL;
						`CBST_OP_RTS: state_d = ST_POPP;
						`CBST_OP_RTE: state_d = ST_POPC;
						`CBST_OP_SLEEP: state_d = ST_HALT;
						`CBST_OP_MOVE: state_d = (instr_count != 8'h00) ? ST_MVR : ST_EXEC;
						default: state_d = ST_EXEC;
					endcase
				end
			end
			ST_CALL: begin
				if (bus_done) begin
					state_d = ST_EXEC;
				end
			end
			ST_XPC: begin
				if (bus_done) begin
					state_d = ST_XCCR;
				end
			end
			ST_XCCR: begin
				if (bus_done) begin
					state_d = ST_XVEC;
				end
			end
			ST_POPC: begin
				if (bus_done) begin
					state_d = ST_POPP;
				end
			end
			ST_MVR: begin
				if (bus_done) begin
					state_d = ST_MVW;
				end
			end
			ST_MVW: begin
				if (bus_done) begin
					state_d = (mv_count_q == 8'h01) ? ST_EXEC : ST_MVR;
				end
			end
			ST_HALT: begin
				if (wake || irq_req) begin
					state_d = ST_EXEC;
				end
			end
			default: state_d = ST_RST;
		endcase
	end

	// access wanted by the current state
	always @* begin
		acc_addr = sp_q;
		acc_wdata = 16'h0000;
		acc_we = 1'b0;
		acc_word = 1'b1;
		case (state_q)
			ST_VEC: acc_addr = `CBST_RESET_VEC;
			ST_CALL, ST_XPC: begin
				acc_addr = sp_q - 16'h0002;
				acc_wdata = ret_q;
				acc_we = 1'b1;
			end
			ST_XCCR: begin
				acc_addr = sp_q - 16'h0002;
				acc_wdata = {ccr_q, ccr_q};
				acc_we = 1'b1;
			end
			ST_XVEC: acc_addr = vec_q;
			ST_MVR: begin
				acc_addr = mv_src_q;
				acc_word = 1'b0;
			end
			ST_MVW: begin
				acc_addr = mv_dst_q;
				acc_wdata = {8'h00, mv_byte_q};
				acc_we = 1'b1;
				acc_word = 1'b0;
			end
			default: acc_addr = sp_q;
		endcase
	end

	// bus cycle engine: one launch cycle, then two or three states
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_req_q <= 1'b0;
			bus_we_q <= 1'b0;
			bus_word_q <= 1'b0;
			bus_three_q <= 1'b0;
			bus_state_q <= 2'h0;
			bus_last_q <= `CBST_LAST_2ST;
			bus_addr_q <= 16'h0000;
			bus_wdata_q <= 16'h0000;
		end else if (bus_done) begin
			bus_req_q <= 1'b0;
			bus_state_q <= 2'h0;
		end else if (bus_req_q) begin
			bus_state_q <= bus_state_q + 2'h1;
		end else if (!bus_idle_st) begin
			bus_req_q <= 1'b1;
			bus_state_q <= 2'h0;
			bus_addr_q <= acc_addr;
			bus_wdata_q <= acc_wdata;
			bus_we_q <= acc_we;
			// peripheral window is byte wide; memory keeps the requested size
			bus_word_q <= acc_word && !in_win(acc_addr, peri_lo_q, peri_hi_q);
			// three states only inside both windows, memory always two
			if (in_win(acc_addr, peri_lo_q, peri_hi_q) && in_win(acc_addr, slow_lo_q, slow_hi_q)) begin
				bus_three_q <= 1'b1;
				bus_last_q <= `CBST_LAST_3ST;
			end else begin
				bus_three_q <= 1'b0;
				bus_last_q <= `CBST_LAST_2ST;
			end
		end
	end

	// sequencer, program counter, flags and stack
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_RST;
			cpu_state_q <= `CBST_CPU_RESET;
			instr_ready_q <= 1'b0;
			pc_q <= 16'h0000;
			ccr_q <= `CBST_RST_CCR;
			sp_q <= `CBST_RST_SP;
			ret_q <= 16'h0000;
			tgt_q <= 16'h0000;
			vec_q <= 16'h0000;
			halt_mode_q <= `CBST_HALT_SLEEP_HI;
			gr_wr_q <= 1'b0;
			gr_idx_q <= 3'h0;
			gr_wdata_q <= 8'h00;
			mv_wb_q <= 1'b0;
			mv_count_q <= 8'h00;
			mv_src_q <= 16'h0000;
			mv_dst_q <= 16'h0000;
			mv_byte_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cpu_state_q <= cpu_class(state_d);
			instr_ready_q <= (state_d == ST_EXEC);
			gr_wr_q <= 1'b0;
			mv_wb_q <= 1'b0;
			if (reg_wr && reg_addr == `CBST_REG_SP) begin
				sp_q <= reg_wdata;
			end
			case (state_q)
				ST_VEC: begin
					if (bus_done) begin
						pc_q <= bus_rdata;
					end
				end
				ST_EXEC: begin
					if (irq_take) begin
						ret_q <= pc_q;
						vec_q <= irq_vec;
					end else if (accept) begin
						pc_q <= pc_inc;
						case (instr_op)
							`CBST_OP_BCC: begin
								if (cond_true(instr_cond, ccr_q)) begin
									pc_q <= pc_rel;
								end
							end
							`CBST_OP_JMP: pc_q <= instr_addr;
							`CBST_OP_BSR: begin
								ret_q <= pc_inc;
								tgt_q <= pc_rel;
							end
							`CBST_OP_JSR: begin
								ret_q <= pc_inc;
								tgt_q <= instr_addr;
							end
							`CBST_OP_RTS, `CBST_OP_RTE: pc_q <= pc_q;
							`CBST_OP_SLEEP: begin
								// out-of-range selections fall back to high-speed sleep
								if (cfg_halt_q > `CBST_HALT_SUBSLEEP) begin
									halt_mode_q <= `CBST_HALT_SLEEP_HI;
								end else begin
									halt_mode_q <= cfg_halt_q;
								end
							end
							`CBST_OP_LDCI: ccr_q <= instr_imm;
							`CBST_OP_LDCR: ccr_q <= instr_rdata;
							`CBST_OP_STC: begin
								gr_wr_q <= 1'b1;
								gr_idx_q <= instr_ridx;
								gr_wdata_q <= ccr_q;
							end
							`CBST_OP_AND_COND_CODES: ccr_q <= ccr_q & instr_imm;
							`CBST_OP_ORC: ccr_q <= ccr_q | instr_imm;
							`CBST_OP_XOR_COND_CODES: ccr_q <= ccr_q ^ instr_imm;
							`CBST_OP_MOVE: begin
								mv_count_q <= instr_count;
								mv_src_q <= instr_src;
								mv_dst_q <= instr_dst;
								mv_wb_q <= (instr_count == 8'h00);
							end
							default: pc_q <= pc_inc;
						endcase
					end
				end
				ST_CALL: begin
					if (bus_done) begin
						sp_q <= sp_q - 16'h0002;
						pc_q <= tgt_q;
					end
				end
				ST_XPC, ST_XCCR: begin
					if (bus_done) begin
						sp_q <= sp_q - 16'h0002;
					end
				end
				ST_XVEC: begin
					if (bus_done) begin
						pc_q <= bus_rdata;
						ccr_q[`CBST_CC_I] <= 1'b1;
					end
				end
				ST_POPC: begin
					if (bus_done) begin
						ccr_q <= bus_rdata[7:0];
						sp_q <= sp_q + 16'h0002;
					end
				end
				ST_POPP: begin
					if (bus_done) begin
						pc_q <= bus_rdata;
						sp_q <= sp_q + 16'h0002;
					end
				end
				ST_MVR: begin
					if (bus_done) begin
						mv_byte_q <= bus_rdata[7:0];
						mv_src_q <= mv_src_q + 16'h0001;
					end
				end
				ST_MVW: begin
					if (bus_done) begin
						mv_dst_q <= mv_dst_q + 16'h0001;
						mv_count_q <= mv_count_q - 8'h01;
						mv_wb_q <= (mv_count_q == 8'h01);
					end
				end
				default: pc_q <= pc_q;
			endcase
		end
	end

	// configuration writes and registered read data
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			peri_lo_q <= `CBST_RST_PERI_LO;
			peri_hi_q <= `CBST_RST_PERI_HI;
			slow_lo_q <= `CBST_RST_SLOW_LO;
			slow_hi_q <= `CBST_RST_SLOW_HI;
			cfg_run_q <= 2'h0;
			cfg_halt_q <= 3'h0;
			reg_rdata_q <= 16'h0000;
		end else begin
			if (reg_wr) begin
				if (reg_addr == `CBST_REG_PERI_LO) begin
					peri_lo_q <= reg_wdata;
				end else if (reg_addr == `CBST_REG_PERI_HI) begin
					peri_hi_q <= reg_wdata;
				end else if (reg_addr == `CBST_REG_SLOW_LO) begin
					slow_lo_q <= reg_wdata;
				end else if (reg_addr == `CBST_REG_SLOW_HI) begin
					slow_hi_q <= reg_wdata;
				end else if (reg_addr == `CBST_REG_MODE) begin
					cfg_run_q <= reg_wdata[`CBST_MODE_RUN_LSB+1:`CBST_MODE_RUN_LSB];
					cfg_halt_q <= reg_wdata[`CBST_MODE_HALT_LSB+2:`CBST_MODE_HALT_LSB];
				end
			end
			reg_rdata_q <= 16'h0000;
			if (reg_rd) begin
				if (reg_addr == `CBST_REG_PERI_LO) begin
					reg_rdata_q <= peri_lo_q;
				end else if (reg_addr == `CBST_REG_PERI_HI) begin
					reg_rdata_q <= peri_hi_q;
				end else if (reg_addr == `CBST_REG_SLOW_LO) begin
					reg_rdata_q <= slow_lo_q;
				end else if (reg_addr == `CBST_REG_SLOW_HI) begin
					reg_rdata_q <= slow_hi_q;
				end else if (reg_addr == `CBST_REG_MODE) begin
					reg_rdata_q <= {9'h000, cfg_halt_q, 2'h0, cfg_run_q};
				end else if (reg_addr == `CBST_REG_STATUS) begin
					reg_rdata_q <= {9'h000, halt_mode_q, 2'h0, cpu_state_q};
				end else if (reg_addr == `CBST_REG_PC) begin
					reg_rdata_q <= pc_q;
				end else if (reg_addr == `CBST_REG_CCR) begin
					reg_rdata_q <= {8'h00, ccr_q};
				end else if (reg_addr == `CBST_REG_SP) begin
					reg_rdata_q <= sp_q;
				end
			end
		end
	end

	// clock source choice; the clock generator itself sits outside
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_mode_q <= 2'h0;
			clk_sub_sel_q <= 1'b0;
		end else begin
			run_mode_q <= cfg_run_q;
			if (state_q == ST_HALT) begin
				clk_sub_sel_q <= (halt_mode_q == `CBST_HALT_SUBSLEEP);
			end else begin
				clk_sub_sel_q <= (cfg_run_q == `CBST_RUN_SUB);
			end
		end
	end
endmodule

// ---- dv/cbst_core_asserts.sv ----
`timescale 1ns/100ps
`include "cbst_regs.vh"
module cbst_checker (
	input wire clk_sys,
	input wire rst,
	input wire instr_valid,
	input wire instr_ready_q,
	input wire [3:0] instr_op,
	input wire [7:0] instr_count,
	input wire gr_wr_q,
	input wire [7:0] gr_wdata_q,
	input wire [7:0] ccr_q,
	input wire mv_wb_q,
	input wire [7:0] mv_count_q,
	input wire bus_req_q,
	input wire bus_word_q,
	input wire bus_three_q,
	input wire [1:0] bus_state_q,
	input wire [1:0] cpu_state_q,
	input wire [2:0] halt_mode_q,
	input wire [1:0] run_mode_q,
	input wire clk_sub_sel_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// instruction taken on this edge
	wire acc = instr_valid && instr_ready_q;
	// each access starts at state 0 and lets go right after its last state
	a_bus_two_state: assert property (
		$rose(bus_req_q) && !bus_three_q |-> bus_state_q == 2'h0 ##1 bus_req_q && bus_state_q == 2'h1 ##1 !bus_req_q)
		else $error("two-state access malformed");
	a_bus_three_state: assert property (
		$rose(bus_req_q) && bus_three_q |-> bus_state_q == 2'h0 ##1 bus_req_q && bus_state_q == 2'h1
		##1 bus_req_q && bus_state_q == 2'h2 ##1 !bus_req_q)
		else $error("three-state access malformed");
	a_peri_byte_only: assert property (bus_req_q && bus_three_q |-> !bus_word_q)
		else $error("word access in slow window");
	a_ready_exec: assert property (instr_ready_q |-> cpu_state_q == `CBST_CPU_EXEC)
		else $error("ready outside execution state");
	a_sleep_halts: assert property (acc && instr_op == `CBST_OP_SLEEP |-> ##[1:4] cpu_state_q == `CBST_CPU_HALT)
		else $error("sleep did not halt");
	a_halt_mode_range: assert property (cpu_state_q == `CBST_CPU_HALT |-> halt_mode_q <= 3'h4)
		else $error("undefined halt mode");
	a_sub_clock: assert property (
		cpu_state_q == `CBST_CPU_EXEC && $stable(cpu_state_q) && $stable(run_mode_q)
		|-> clk_sub_sel_q == (run_mode_q == `CBST_RUN_SUB))
		else $error("clock select disagrees with run mode");
	a_stc_copy: assert property (gr_wr_q |-> gr_wdata_q == ccr_q && $stable(ccr_q))
		else $error("stored flags differ");
	// a zero count moves nothing, so only a real transfer drops ready
	a_move_waits: assert property (
		acc && instr_op == `CBST_OP_MOVE && instr_count != 8'h00 |=> !instr_ready_q)
		else $error("ready during block move");
	a_move_done: assert property (
		mv_wb_q |-> instr_ready_q && mv_count_q == 8'h00
		&& (!$past(instr_ready_q) || $past(instr_count) == 8'h00))
		else $error("block move end malformed");
	a_nop_ready: assert property (acc && instr_op == `CBST_OP_NOP |=> instr_ready_q)
		else $error("nop stalled");
endmodule
bind cbst_core cbst_checker u_chk (.*);

// ---- dv/cbst_mem_model.sv ----
`timescale 1ns/100ps
module cbst_mem_model #(
	parameter logic [15:0] RESET_VEC = 16'h0200
) (
	input wire clk_sys,
	input wire bus_req_q,
	input wire bus_we_q,
	input wire bus_word_q,
	input wire bus_three_q,
	input wire [1:0] bus_state_q,
	input wire [15:0] bus_addr_q,
	input wire [15:0] bus_wdata_q,
	output logic [15:0] bus_rdata
);
	logic [7:0] mem [0:65535];
	logic [15:0] held_q = 16'h0000;
	wire [15:0] a_ev = {bus_addr_q[15:1], 1'b0};
	wire at_end = bus_req_q && bus_state_q == (bus_three_q ? 2'h2 : 2'h1);
	// preset content so no read returns unknowns
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0];
		{mem[0], mem[1]} = RESET_VEC;
	end
	// data only in the last state, elsewhere a toggling pattern so stale data cannot pass
	always_comb begin
		if (!at_end) bus_rdata = ~held_q;
		else if (bus_word_q) bus_rdata = {mem[a_ev], mem[a_ev + 16'h1]};
		else bus_rdata = {8'h00, mem[bus_addr_q]};
	end
	// writes land in the last state, high byte at the even address
	always @(posedge clk_sys) begin
		held_q <= bus_rdata;
		if (at_end && bus_we_q && bus_word_q) {mem[a_ev], mem[a_ev + 16'h1]} <= bus_wdata_q;
		else if (at_end && bus_we_q) mem[bus_addr_q] <= bus_wdata_q[7:0];
	end
endmodule

// ---- dv/test_cpu_branch_sysctl_bus_timing.sv ----
`timescale 1ns/100ps
`include "cbst_regs.vh"
module test_cpu_branch_sysctl_bus_timing;
	localparam logic [15:0] VEC = 16'h0200;
	logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, instr_valid = 0, irq_req = 0, wake = 0;
	logic [3:0] reg_addr = 0, instr_op = 0, instr_cond = 0;
	logic [15:0] reg_wdata = 0, instr_addr = 0, instr_src = 0, instr_dst = 0, irq_vec = 0, ep, es;
	logic [7:0] instr_disp = 0, instr_imm = 0, instr_rdata = 0, instr_count = 0;
	logic [2:0] instr_ridx = 0;
	wire [15:0] reg_rdata_q, bus_addr_q, bus_wdata_q, bus_rdata, pc_q, sp_q, mv_src_q, mv_dst_q;
	wire [7:0] gr_wdata_q, mv_count_q, ccr_q;
	wire [2:0] gr_idx_q, halt_mode_q;
	wire [1:0] bus_state_q, cpu_state_q, run_mode_q;
	wire instr_ready_q, gr_wr_q, mv_wb_q, bus_req_q, bus_we_q, bus_word_q, bus_three_q, clk_sub_sel_q;
	integer error_cnt = 0, n_checks = 0, n3 = 0;
	cbst_core u_dut (.*);
	cbst_mem_model #(.RESET_VEC(VEC)) u_mem (.*);
	initial forever #4 clk_sys = ~clk_sys;
	// count third states of writes, only slow-window accesses have one
	always @(posedge clk_sys) if (bus_req_q && bus_we_q && bus_state_q == 2'h2) n3 <= n3 + 1;
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks++;
			if (got !== exp) begin
				error_cnt++;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", n_checks, error_cnt);
			if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	// bounded wait for the sequencer to offer ready again
	task wait_rdy;
		integer k;
		begin
			k = 0;
			@(posedge clk_sys);
			while (instr_ready_q !== 1'b1 && k < 200) begin
				@(posedge clk_sys);
				k++;
			end
			if (k == 200) error_cnt++;
		end
	endtask
	task take(input [3:0] o);
		begin
			instr_op <= o;
			instr_valid <= 1'b1;
			wait_rdy;
			instr_valid <= 1'b0;
		end
	endtask
	task go(input [3:0] o);
		begin
			take(o);
			wait_rdy;
		end
	endtask
	// strobe then a spare edge, so the next strobe never lands in the same step
	task wr(input [3:0] a, input [15:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task rd(input [3:0] a, output [15:0] d);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			@(posedge clk_sys);
			d = reg_rdata_q;
		end
	endtask
	// f holds N Z V C, odd codes invert the even ones
	function logic tk(input [3:0] c, input [3:0] f);
		logic [7:0] b;
		begin
			b = {~(f[2] | (f[3] ^ f[1])), ~(f[3] ^ f[1]), ~f[3], ~f[1], ~f[2], ~f[0], ~(f[0] | f[2]), 1'b1};
			tk = b[c[3:1]] ^ c[0];
		end
	endfunction
	task t_reset;
		logic [15:0] d;
		begin
			repeat (8) @(posedge clk_sys);
			chk({8'h00, ccr_q}, 16'h0080);
			chk(sp_q, 16'hff80);
			chk({14'h0, cpu_state_q}, {14'h0, `CBST_CPU_RESET});
			rst <= 1'b0;
			repeat (2) @(posedge clk_sys);
			chk({14'h0, cpu_state_q}, {14'h0, `CBST_CPU_EXC});
			wait_rdy;
			chk(pc_q, VEC);
			wr(`CBST_REG_PC, 16'hbeef);
			rd(`CBST_REG_PC, d);
			chk(d, VEC);
			rd(4'hf, d);
			chk(d, 16'h0000);
			ep = VEC;
			es = 16'hff80;
		end
	endtask
	task t_branch;
		integer f, c;
		begin
			instr_disp <= 8'hf6;
			for (f = 0; f < 16; f++) begin
				instr_imm <= {4'h8, f[3:0]};
				go(`CBST_OP_LDCI);
				ep = ep + 16'h2;
				chk({8'h00, ccr_q}, {12'h008, f[3:0]});
				for (c = 0; c < 16; c++) begin
					instr_cond <= c[3:0];
					go(`CBST_OP_BCC);
					ep = ep + 16'h2 + (tk(c[3:0], f[3:0]) ? 16'hfff6 : 16'h0);
					chk(pc_q, ep);
				end
			end
		end
	endtask
	task t_ccr;
		integer k;
		logic [7:0] e;
		begin
			instr_rdata <= 8'h25;
			go(`CBST_OP_LDCR);
			e = 8'h25;
			instr_imm <= 8'h6a;
			for (k = 0; k < 3; k++) begin
				go(`CBST_OP_AND_COND_CODES + k[3:0]);
				e = (k == 0) ? (e & 8'h6a) : (k == 1) ? (e | 8'h6a) : (e ^ 8'h6a);
				chk({8'h00, ccr_q}, {8'h00, e});
			end
			instr_ridx <= 3'h5;
			go(`CBST_OP_STC);
			chk({gr_wr_q, gr_idx_q, 4'h0, gr_wdata_q}, {4'hd, 4'h0, e});
			go(`CBST_OP_NOP);
			ep = ep + 16'hc;
			chk(pc_q, ep);
			chk({8'h00, ccr_q}, {8'h00, e});
		end
	endtask
	task t_call;
		integer k;
		logic [15:0] tgt;
		begin
			instr_addr <= 16'h1234;
			go(`CBST_OP_JMP);
			ep = 16'h1234;
			chk(pc_q, ep);
			instr_addr <= 16'h2468;
			instr_disp <= 8'h20;
			for (k = 0; k < 2; k++) begin
				tgt = k ? ep + 16'h22 : 16'h2468;
				go(k ? `CBST_OP_BSR : `CBST_OP_JSR);
				chk(pc_q, tgt);
				chk(sp_q, es - 16'h2);
				chk({u_mem.mem[es - 16'h2], u_mem.mem[es - 16'h1]}, ep + 16'h2);
				go(`CBST_OP_RTS);
				ep = ep + 16'h2;
				chk(pc_q, ep);
				chk(sp_q, es);
			end
		end
	endtask
	task t_irq;
		begin
			{u_mem.mem[16'h0010], u_mem.mem[16'h0011]} = 16'h0400;
			irq_vec <= 16'h0010;
			instr_imm <= 8'h05;
			go(`CBST_OP_LDCI);
			ep = ep + 16'h2;
			irq_req <= 1'b1;
			repeat (3) @(posedge clk_sys);
			irq_req <= 1'b0;
			wait_rdy;
			chk(pc_q, 16'h0400);
			chk(sp_q, es - 16'h4);
			chk({u_mem.mem[es - 16'h2], u_mem.mem[es - 16'h1]}, ep);
			chk({8'h00, u_mem.mem[es - 16'h3]}, 16'h0005);
			chk({15'h0, ccr_q[7]}, 16'h0001);
			go(`CBST_OP_RTE);
			chk(pc_q, ep);
			chk({8'h00, ccr_q}, 16'h0005);
			chk(sp_q, es);
		end
	endtask
	task t_move;
		integer k;
		begin
			wr(`CBST_REG_SLOW_LO, 16'hffa0);
			wr(`CBST_REG_SLOW_HI, 16'hffa7);
			{u_mem.mem[16'hfc00], u_mem.mem[16'hfc01], u_mem.mem[16'hfc02]} = 24'ha1b2c3;
			instr_count <= 8'h03;
			instr_src <= 16'hfc00;
			instr_dst <= 16'hffa6;
			k = n3;
			go(`CBST_OP_MOVE);
			chk({u_mem.mem[16'hffa6], u_mem.mem[16'hffa8]}, 16'ha1c3);
			chk({7'h0, mv_wb_q, mv_count_q}, 16'h0100);
			chk(mv_src_q, 16'hfc03);
			chk(mv_dst_q, 16'hffa9);
			chk(16'(n3 - k), 16'h0002);
			instr_count <= 8'h00;
			instr_src <= 16'hfc01;
			instr_dst <= 16'hfc00;
			go(`CBST_OP_MOVE);
			ep = ep + 16'h4;
			chk({8'h00, u_mem.mem[16'hfc00]}, 16'h00a1);
			chk(mv_src_q, 16'hfc01);
			chk({7'h0, mv_wb_q, mv_count_q}, 16'h0100);
			chk(pc_q, ep);
		end
	endtask
	task t_sleep;
		integer m;
		logic [2:0] h;
		logic [15:0] d;
		begin
			// code 5 is out of range and must fall back to high-speed sleep
			for (m = 0; m < 6; m++) begin
				h = (m == 5) ? 3'h0 : m[2:0];
				wr(`CBST_REG_MODE, {9'h000, m[2:0], 2'h0, (m >= 4) ? 2'h2 : 2'h0});
				take(`CBST_OP_SLEEP);
				repeat (3) @(posedge clk_sys);
				chk({14'h0, cpu_state_q}, {14'h0, `CBST_CPU_HALT});
				chk({13'h0, halt_mode_q}, {13'h0, h});
				chk({15'h0, clk_sub_sel_q}, {15'h0, m == 4});
				rd(`CBST_REG_STATUS, d);
				chk(d, {9'h000, h, 2'h0, `CBST_CPU_HALT});
				wake <= 1'b1;
				wait_rdy;
				wake <= 1'b0;
				ep = ep + 16'h2;
				chk(pc_q, ep);
			end
			@(posedge clk_sys);
			chk({15'h0, clk_sub_sel_q}, 16'h0001);
			chk({14'h0, run_mode_q}, {14'h0, `CBST_RUN_SUB});
			wr(`CBST_REG_MODE, 16'h0000);
		end
	endtask
	initial begin
		t_reset;
		t_branch;
		t_ccr;
		t_call;
		t_irq;
		t_move;
		t_sleep;
		print_verdict;
	end
	// watchdog, roughly thirty-five times the expected run
	initial begin
		#200000;
		error_cnt++;
		print_verdict;
	end
endmodule
